// File: hdl/imd_pkg.sv
// Package of constants and types for the integer multiply datapath
package imd_pkg;
  localparam int IMD_WORD_W = 16;
  localparam int IMD_PROD_W = 32;
  localparam int IMD_LIT_W = 5;
  localparam int IMD_REG_IDX_W = 4;
  localparam logic [3:0] IMD_PAIR_HI_REG = 4'h3;
  localparam logic [3:0] IMD_PAIR_LO_REG = 4'h2;
  localparam int IMD_ACC_W = 40;
  // Cycles per instruction; an SFR read adds one
  localparam int IMD_BASE_CYCLES = 1;
  localparam int IMD_SFR_EXTRA_CYCLES = 1;

  // Operation forms
  typedef enum logic [3:0] {
    IMD_OP_PAIR_REG,
    IMD_OP_ACC_REG,
    IMD_OP_ACC_LIT,
    IMD_OP_PAIR_LIT,
    IMD_OP_WORD_LIT,
    IMD_OP_WORD_REG,
    IMD_OP_FILE
  } imd_op_t;

  typedef enum logic {
    IMD_ST_IDLE,
    IMD_ST_SFR_WAIT
  } imd_state_t;
endpackage : imd_pkg

// File: hdl/imd_multiply.sv
// Integer multiply datapath of the 16-bit core
`timescale 1ns/1ps
`default_nettype none
module imd_multiply
  import imd_pkg::*;
#(
  parameter bit HAS_ACC = 1'b1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic opValid,
  input wire imd_op_t opForm,
  input wire logic baseSigned,
  input wire logic sourceSigned,
  input wire logic [IMD_WORD_W-1:0] baseRegister,
  input wire logic [IMD_WORD_W-1:0] sourceRegister,
  input wire logic [IMD_LIT_W-1:0] fiveBitLiteral,
  input wire logic [IMD_WORD_W-1:0] fileWord,
  input wire logic [IMD_WORD_W-1:0] defaultWorkingRegister,
  input wire logic fileIsSfr,
  input wire logic [IMD_REG_IDX_W-1:0] destReg,
  input wire logic accSelect,
  output logic busy,
  output logic illegalOp,
  output logic wrLoEn,
  output logic [IMD_REG_IDX_W-1:0] wrLoIdx,
  output logic [IMD_WORD_W-1:0] wrLoData,
  output logic wrHiEn,
  output logic [IMD_REG_IDX_W-1:0] wrHiIdx,
  output logic [IMD_WORD_W-1:0] wrHiData,
  output logic accWrEn,
  output logic accWrSel,
  output logic [IMD_ACC_W-1:0] accWrData,
  output logic flagsWrEn
);

  // ------------------------------------------------------------
  // Operand shaping
  // ------------------------------------------------------------
  logic useLit;
  logic aSign;
  logic bSign;
  logic [IMD_WORD_W-1:0] opA;
  logic [IMD_WORD_W-1:0] opB;
  logic signed [IMD_WORD_W:0] extA;
  logic signed [IMD_WORD_W:0] extB;
  logic signed [2*IMD_WORD_W+1:0] fullProd;
  logic [IMD_PROD_W-1:0] product;

  always_comb begin
    useLit = (opForm == IMD_OP_ACC_LIT) || (opForm == IMD_OP_PAIR_LIT) ||
             (opForm == IMD_OP_WORD_LIT);
    // Literal is always unsigned; file form is unsigned by unsigned
    aSign = (opForm == IMD_OP_FILE) ? 1'b0 : baseSigned;
    bSign = (useLit || opForm == IMD_OP_FILE) ? 1'b0 : sourceSigned;
    opA = (opForm == IMD_OP_FILE) ? fileWord : baseRegister;
    opB = (opForm == IMD_OP_FILE) ? defaultWorkingRegister :
          useLit ? {{(IMD_WORD_W-IMD_LIT_W){1'b0}}, fiveBitLiteral} : sourceRegister;
    // One extra sign bit makes one signed multiplier serve all four mixes
    extA = $signed({aSign & opA[IMD_WORD_W-1], opA});
    extB = $signed({bSign & opB[IMD_WORD_W-1], opB});
    fullProd = extA * extB;
    product = fullProd[IMD_PROD_W-1:0];
  end

  // ------------------------------------------------------------
  // Decode legality
  // ------------------------------------------------------------
  logic isAcc;
  logic isPair;
  logic isWord;
  logic illegal;

  always_comb begin
    isAcc = (opForm == IMD_OP_ACC_REG) || (opForm == IMD_OP_ACC_LIT);
    isPair = (opForm == IMD_OP_PAIR_REG) || (opForm == IMD_OP_PAIR_LIT);
    isWord = (opForm == IMD_OP_WORD_REG) || (opForm == IMD_OP_WORD_LIT);
    illegal = (isAcc && !HAS_ACC) ||
              (isPair && destReg[0]) ||
              !(isAcc || isPair || isWord || opForm == IMD_OP_FILE);
  end

  // ------------------------------------------------------------
  // Issue control and SFR stall
  // ------------------------------------------------------------
  imd_state_t state_r;
  imd_state_t state_nxt;
  logic fire;

  always_comb begin
    state_nxt = state_r;
    fire = 1'b0;
    case (state_r)
      IMD_ST_IDLE: begin
        if (opValid) begin
          // SFR operand needs a second cycle before the write
          if (opForm == IMD_OP_FILE && fileIsSfr) begin
            state_nxt = IMD_ST_SFR_WAIT;
          end else begin
            fire = 1'b1;
          end
        end
      end
      IMD_ST_SFR_WAIT: begin
        fire = 1'b1;
        state_nxt = IMD_ST_IDLE;
      end
      default: state_nxt = IMD_ST_IDLE;
    endcase
  end

  // Busy is high only in the issue cycle of an SFR file op; caller must hold operands through the next cycle
  assign busy = (state_r == IMD_ST_IDLE) && opValid && (opForm == IMD_OP_FILE) && fileIsSfr;
  assign flagsWrEn = 1'b0;

  // ------------------------------------------------------------
  // Result registers
  // ------------------------------------------------------------
  logic wrLoEn_nxt;
  logic [IMD_REG_IDX_W-1:0] wrLoIdx_nxt;
  logic [IMD_WORD_W-1:0] wrLoData_nxt;
  logic wrHiEn_nxt;
  logic [IMD_REG_IDX_W-1:0] wrHiIdx_nxt;
  logic [IMD_WORD_W-1:0] wrHiData_nxt;
  logic accWrEn_nxt;
  logic accWrSel_nxt;
  logic [IMD_ACC_W-1:0] accWrData_nxt;
  logic illegalOp_nxt;

  always_comb begin
    wrLoEn_nxt = 1'b0;
    wrLoIdx_nxt = destReg;
    wrLoData_nxt = product[IMD_WORD_W-1:0];
    wrHiEn_nxt = 1'b0;
    wrHiIdx_nxt = destReg | 4'h1;
    wrHiData_nxt = product[IMD_PROD_W-1:IMD_WORD_W];
    accWrEn_nxt = 1'b0;
    accWrSel_nxt = accSelect;
    // Accumulator is sign-extended only when any operand was signed
    accWrData_nxt = {{(IMD_ACC_W-IMD_PROD_W){(aSign | bSign) & product[IMD_PROD_W-1]}},
                     product};
    illegalOp_nxt = 1'b0;
    if (fire) begin
      if (illegal) begin
        illegalOp_nxt = 1'b1;
      end else if (isAcc) begin
        accWrEn_nxt = 1'b1;
      end else if (isPair) begin
        wrLoEn_nxt = 1'b1;
        wrHiEn_nxt = 1'b1;
      end else if (isWord) begin
        wrLoEn_nxt = 1'b1;
      end else begin
        wrLoEn_nxt = 1'b1;
        wrLoIdx_nxt = IMD_PAIR_LO_REG;
        wrHiEn_nxt = 1'b1;
        wrHiIdx_nxt = IMD_PAIR_HI_REG;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= IMD_ST_IDLE;
      wrLoEn <= 1'b0;
      wrLoIdx <= 4'h0;
      wrLoData <= 16'h0000;
      wrHiEn <= 1'b0;
      wrHiIdx <= 4'h0;
      wrHiData <= 16'h0000;
      accWrEn <= 1'b0;
      accWrSel <= 1'b0;
      accWrData <= 40'h0000000000;
      illegalOp <= 1'b0;
    end else begin
      state_r <= state_nxt;
      wrLoEn <= wrLoEn_nxt;
      wrLoIdx <= wrLoIdx_nxt;
      wrLoData <= wrLoData_nxt;
      wrHiEn <= wrHiEn_nxt;
      wrHiIdx <= wrHiIdx_nxt;
      wrHiData <= wrHiData_nxt;
      accWrEn <= accWrEn_nxt;
      accWrSel <= accWrSel_nxt;
      accWrData <= accWrData_nxt;
      illegalOp <= illegalOp_nxt;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_sfr_issue;
    opValid && opForm == IMD_OP_FILE && fileIsSfr && state_r == IMD_ST_IDLE;
  endsequence
  sequence s_sfr_write;
    wrLoEn && wrHiEn && wrLoIdx == IMD_PAIR_LO_REG && wrHiIdx == IMD_PAIR_HI_REG;
  endsequence

  property p_sfr_extra;
    @(posedge clk) disable iff (!rstn) s_sfr_issue |=> (!wrLoEn && !wrHiEn) ##1 s_sfr_write;
  endproperty
  a_sfr_extra: assert property (p_sfr_extra) else $error("SFR multiply timing wrong");

  property p_one_cycle;
    @(posedge clk) disable iff (!rstn)
      (state_r == IMD_ST_IDLE && opValid && !busy && !illegal) |=>
        (wrLoEn || accWrEn);
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("multiply not done in one cycle");

  property p_flags;
    @(posedge clk) disable iff (!rstn) !flagsWrEn;
  endproperty
  a_flags: assert property (p_flags) else $error("status flags written");

  property p_pair_hi;
    @(posedge clk) disable iff (!rstn)
      (fire && isPair && !illegal) |=>
        wrHiEn && wrHiIdx == (wrLoIdx + 4'h1) && {wrHiData, wrLoData} == $past(product);
  endproperty
  a_pair_hi: assert property (p_pair_hi) else $error("pair result wrong");

  property p_word_only;
    @(posedge clk) disable iff (!rstn)
      (fire && isWord && !illegal) |=> wrLoEn && !wrHiEn && wrLoData == $past(product[15:0]);
  endproperty
  a_word_only: assert property (p_word_only) else $error("word form touched pair");

  property p_acc_only;
    @(posedge clk) disable iff (!rstn)
      (fire && isAcc && !illegal) |=> accWrEn && !wrLoEn && !wrHiEn;
  endproperty
  a_acc_only: assert property (p_acc_only) else $error("acc form wrote registers");

  property p_odd_pair;
    @(posedge clk) disable iff (!rstn)
      (fire && isPair && destReg[0]) |=> illegalOp && !wrLoEn && !wrHiEn;
  endproperty
  a_odd_pair: assert property (p_odd_pair) else $error("odd pair not refused");

  property p_no_acc;
    @(posedge clk) disable iff (!rstn) !HAS_ACC |-> !accWrEn;
  endproperty
  a_no_acc: assert property (p_no_acc) else $error("acc written without variant");

  property p_lit_unsigned;
    @(posedge clk) disable iff (!rstn)
      (fire && opForm == IMD_OP_PAIR_LIT && !illegal && !baseSigned) |=>
        {wrHiData, wrLoData} == $past(baseRegister) * $past({11'h000, fiveBitLiteral});
  endproperty
  a_lit_unsigned: assert property (p_lit_unsigned) else $error("literal product wrong");

  property p_ss_pair;
    @(posedge clk) disable iff (!rstn)
      (fire && opForm == IMD_OP_PAIR_REG && !illegal && baseSigned && sourceSigned) |=>
        $signed({wrHiData, wrLoData}) ==
          $signed($past(baseRegister)) * $signed($past(sourceRegister));
  endproperty
  a_ss_pair: assert property (p_ss_pair) else $error("signed pair product wrong");

  property p_su_pair;
    @(posedge clk) disable iff (!rstn)
      (fire && opForm == IMD_OP_PAIR_REG && !illegal && baseSigned && !sourceSigned) |=>
        $signed({wrHiData, wrLoData}) ==
          $signed($past(baseRegister)) * $signed({1'b0, $past(sourceRegister)});
  endproperty
  a_su_pair: assert property (p_su_pair) else $error("mixed pair product wrong");

  property p_uu_pair;
    @(posedge clk) disable iff (!rstn)
      (fire && opForm == IMD_OP_PAIR_REG && !illegal && !baseSigned && !sourceSigned) |=>
        {wrHiData, wrLoData} == $past(baseRegister) * $past(sourceRegister);
  endproperty
  a_uu_pair: assert property (p_uu_pair) else $error("unsigned pair product wrong");

  property p_file_dest;
    @(posedge clk) disable iff (!rstn)
      (fire && opForm == IMD_OP_FILE) |=>
        wrLoIdx == IMD_PAIR_LO_REG && wrHiIdx == IMD_PAIR_HI_REG &&
        {wrHiData, wrLoData} == $past(fileWord) * $past(defaultWorkingRegister);
  endproperty
  a_file_dest: assert property (p_file_dest) else $error("file product wrong");

  property p_word_lit;
    @(posedge clk) disable iff (!rstn)
      (fire && opForm == IMD_OP_WORD_LIT && !illegal) |=>
        wrLoEn && !wrHiEn && wrLoIdx == $past(destReg) &&
        wrLoData == $past(baseRegister) * $past({11'h000, fiveBitLiteral});
  endproperty
  a_word_lit: assert property (p_word_lit) else $error("word literal result wrong");

  property p_acc_lit;
    @(posedge clk) disable iff (!rstn)
      (fire && opForm == IMD_OP_ACC_LIT && !illegal && baseSigned) |=>
        accWrEn && $signed(accWrData) ==
          $signed($past(baseRegister)) * $signed({1'b0, $past(fiveBitLiteral)});
  endproperty
  a_acc_lit: assert property (p_acc_lit) else $error("acc literal product wrong");

  property p_unknown_form;
    @(posedge clk) disable iff (!rstn)
      (state_r == IMD_ST_IDLE && opValid && opForm > IMD_OP_FILE) |=>
        illegalOp && !wrLoEn && !wrHiEn && !accWrEn;
  endproperty
  a_unknown_form: assert property (p_unknown_form) else $error("unknown form not refused");

endmodule : imd_multiply
`default_nettype wire

// File: test/imd_regfile_model.sv
// Register file and accumulator model that takes the multiply results
`timescale 1ns/1ps
`default_nettype none
module imd_regfile_model
  import imd_pkg::*;
(
  input wire logic clk,
  input wire logic wrLoEn,
  input wire logic [IMD_REG_IDX_W-1:0] wrLoIdx,
  input wire logic [IMD_WORD_W-1:0] wrLoData,
  input wire logic wrHiEn,
  input wire logic [IMD_REG_IDX_W-1:0] wrHiIdx,
  input wire logic [IMD_WORD_W-1:0] wrHiData,
  input wire logic accWrEn,
  input wire logic accWrSel,
  input wire logic [IMD_ACC_W-1:0] accWrData
);
  logic [IMD_WORD_W-1:0] rf [16];
  logic [IMD_ACC_W-1:0] acc [2];
  // Writes land on the edge that sees the enable
  always @(posedge clk) begin
    if (wrLoEn) rf[wrLoIdx] <= wrLoData;
    if (wrHiEn) rf[wrHiIdx] <= wrHiData;
    if (accWrEn) acc[accWrSel] <= accWrData;
  end
endmodule : imd_regfile_model
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench of the integer multiply datapath
`timescale 1ns/1ps
`default_nettype none
module testbench
  import imd_pkg::*;
;
  logic clk = 0, rstn = 0, opValid = 0, bSg = 0, sSg = 0, sfr = 0, accSel = 0, corner = 0;
  imd_op_t form = IMD_OP_PAIR_REG;
  logic [15:0] bR = 0, sR = 0, fW = 0, dW = 0, lastDat = 0;
  logic [4:0] lit = 0;
  logic [3:0] dst = 0, lastIdx = 0;
  logic busy, illegalOp, wrLoEn, wrHiEn, accWrEn, accWrSel, flagsWrEn;
  logic [3:0] wrLoIdx, wrHiIdx;
  logic [15:0] wrLoData, wrHiData;
  logic [39:0] accWrData;
  int error_cnt = 0, comparisons = 0, seed = 57689;
  logic noAccIllegal, noAccWrEn;
  logic lastSel = 0;
  logic [39:0] lastAcc = 0;

  imd_multiply i_imd_multiply (.clk(clk), .rstn(rstn), .opValid(opValid), .opForm(form),
    .baseSigned(bSg), .sourceSigned(sSg), .baseRegister(bR), .sourceRegister(sR),
    .fiveBitLiteral(lit), .fileWord(fW), .defaultWorkingRegister(dW), .fileIsSfr(sfr),
    .destReg(dst), .accSelect(accSel), .busy(busy), .illegalOp(illegalOp),
    .wrLoEn(wrLoEn), .wrLoIdx(wrLoIdx), .wrLoData(wrLoData), .wrHiEn(wrHiEn),
    .wrHiIdx(wrHiIdx), .wrHiData(wrHiData), .accWrEn(accWrEn), .accWrSel(accWrSel),
    .accWrData(accWrData), .flagsWrEn(flagsWrEn));
  imd_regfile_model i_imd_regfile_model (.clk(clk), .wrLoEn(wrLoEn), .wrLoIdx(wrLoIdx),
    .wrLoData(wrLoData), .wrHiEn(wrHiEn), .wrHiIdx(wrHiIdx), .wrHiData(wrHiData),
    .accWrEn(accWrEn), .accWrSel(accWrSel), .accWrData(accWrData));
  // Same stimulus into the variant without accumulators
  if (1) begin : g_noacc
    imd_multiply #(.HAS_ACC(1'b0)) i_imd_multiply (.clk(clk), .rstn(rstn), .opValid(opValid),
      .opForm(form), .baseSigned(bSg), .sourceSigned(sSg), .baseRegister(bR),
      .sourceRegister(sR), .fiveBitLiteral(lit), .fileWord(fW), .defaultWorkingRegister(dW),
      .fileIsSfr(sfr), .destReg(dst), .accSelect(accSel), .busy(), .illegalOp(noAccIllegal),
      .wrLoEn(), .wrLoIdx(), .wrLoData(), .wrHiEn(), .wrHiIdx(), .wrHiData(),
      .accWrEn(noAccWrEn), .accWrSel(), .accWrData(), .flagsWrEn());
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic results;
    $display("mismatches %0d of %0d comparisons", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask : chk

  // Extension to 40 bits makes one product serve every signedness mix
  function automatic logic [39:0] prod(logic [15:0] a, logic [15:0] b, logic as, logic bs);
    return {{24{as & a[15]}}, a} * {{24{bs & b[15]}}, b};
  endfunction : prod

  task automatic issue(input imd_op_t f, input logic bs, input logic ss, input logic sf);
    logic [39:0] p;
    logic pr, ac, fl, lt, ill;
    pr = f inside {IMD_OP_PAIR_REG, IMD_OP_PAIR_LIT};
    ac = f inside {IMD_OP_ACC_REG, IMD_OP_ACC_LIT};
    lt = f inside {IMD_OP_ACC_LIT, IMD_OP_PAIR_LIT, IMD_OP_WORD_LIT};
    fl = f == IMD_OP_FILE;
    opValid = 1;
    form = f;
    bSg = bs;
    sSg = ss;
    sfr = sf;
    dst = 4'($random(seed));
    accSel = 1'($random(seed));
    bR = corner ? (bs ? 16'h8000 : 16'hFFFF) : 16'($random(seed));
    sR = corner ? 16'hFFFF : 16'($random(seed));
    lit = corner ? 5'h1F : 5'($random(seed));
    fW = 16'($random(seed));
    dW = 16'($random(seed));
    ill = (pr && dst[0]) || f > IMD_OP_FILE;
    p = fl ? prod(fW, dW, 1'b0, 1'b0) : lt ? prod(bR, {11'h000, lit}, bs, 1'b0) : prod(bR, sR, bs, ss);
    #1 chk(busy === (sf && fl), "busy");
    @(posedge clk);
    #1;
    // Operands stay held through the extra cycle of a slow file read
    if (sf && fl) begin
      @(posedge clk);
      #1;
    end
    chk(illegalOp === ill, "refusal");
    chk(wrLoEn === (!ill && !ac), "low write");
    chk(wrHiEn === (!ill && (pr || fl)), "high write");
    chk(accWrEn === (!ill && ac), "acc write");
    chk(flagsWrEn === 1'b0, "flags");
    if (!ill && !ac) begin
      lastIdx = fl ? IMD_PAIR_LO_REG : dst;
      lastDat = p[15:0];
      chk(wrLoIdx === lastIdx && wrLoData === lastDat, "low data");
    end
    if (!ill && (pr || fl)) begin
      chk(wrHiIdx === (fl ? IMD_PAIR_HI_REG : (dst | 4'h1)), "high index");
      chk(wrHiData === p[31:16], "high data");
    end
    if (!ill && ac) begin
      chk(accWrSel === accSel && accWrData === p, "acc data");
      lastAcc = p;
      lastSel = accSel;
    end
    chk(noAccIllegal === (ill || ac) && noAccWrEn === 1'b0, "variant refusal");
  endtask : issue

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    #20000;
    error_cnt++;
    results();
  end

  initial begin
    repeat (5) @(posedge clk);
    #1 chk(!wrLoEn && !wrHiEn && !accWrEn && !illegalOp, "reset");
    rstn = 1;
    // Form 7 is unknown; back-to-back ops, corner operands first
    for (int i = 0; i < 240; i++) begin
      corner = i < 48;
      issue(imd_op_t'(i % 8), i[3], i[4], i % 5 == 0);
    end
    opValid = 0;
    @(posedge clk);
    #1 chk(i_imd_regfile_model.rf[lastIdx] === lastDat, "register file");
    chk(i_imd_regfile_model.acc[lastSel] === lastAcc, "accumulator");
    results();
  end
endmodule : testbench
`default_nettype wire
